// ### fssr_shadow_regs.sv
// shadow register bank with field start and readback strobes
// Function
// - writable settings sit in a shadow stage and go active at field start.
// - field start fires when output read enable rises after read start.
// - readable results are captured only at the readback update strobe.
// - readback update fires at half the active pixels of blanking line 4.
// - the soft init register at 25 hex acts at once on write.
// - bit 1 of register 2F hex, the candidate set bit, acts at once.
// - reads of B0 to BF, AE and AF hex return live values unbuffered.
// - field frequent registers are refreshed once per display field.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module fssr_shadow_regs
	import fssr_pkg::*;
#(
	parameter logic [15:0] ACTIVE_PIXELS = ACTIVE_PIXELS_DEF
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	// avalon slave
	input  wire fssr_bus_req_t         avs,
	output logic [DATA_W-1:0]          avsReaddata,
	output logic                       avsWaitrequest,
	// video timing pins
	input  wire fssr_video_t           videoPins,
	// live results from the processing core
	input  wire logic [8*NUM_REGS-1:0] liveResults,
	// active settings and strobes toward the core
	output logic [8*NUM_REGS-1:0]      activeRegs,
	output logic                       softInitPulse,
	output logic                       candidateSetBit,
	output logic                       fieldStart,
	output logic                       readbackUpdate
);
	fssr_video_t sync1;
	fssr_video_t sync2;
	fssr_video_t prevVid;
	logic [DATA_W-1:0] shadow [NUM_REGS];
	logic [DATA_W-1:0] captured [NUM_REGS];
	logic [DATA_W-1:0] next_shadow [NUM_REGS];
	logic [DATA_W-1:0] next_captured [NUM_REGS];
	logic [8*NUM_REGS-1:0] next_activeRegs;
	logic armed;
	logic next_armed;
	logic inBlank;
	logic next_inBlank;
	logic [3:0] blankLine;
	logic [3:0] next_blankLine;
	logic [15:0] pixCount;
	logic [15:0] next_pixCount;
	logic updDone;
	logic next_updDone;
	logic next_fieldStart;
	logic next_readbackUpdate;
	logic next_softInitPulse;
	logic next_candidateSetBit;
	logic [DATA_W-1:0] next_avsReaddata;
	logic next_avsWaitrequest;
	logic [7:0] fieldCount;
	logic [7:0] next_fieldCount;
	logic accessDone;
	logic isDirect;

	// two-stage pin synchroniser
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
			prevVid <= '0;
		end else begin
			sync1 <= videoPins;
			sync2 <= sync1;
			prevVid <= sync2;
		end
	end

	// strobe generation
	always_comb begin
		next_armed = armed;
		next_fieldStart = 1'b0;
		next_inBlank = inBlank;
		next_blankLine = blankLine;
		next_pixCount = pixCount;
		next_updDone = updDone;
		next_readbackUpdate = 1'b0;
		next_fieldCount = fieldCount;
		if (sync2.readStartPulse)
			next_armed = 1'b1;
		if (armed && sync2.outputReadEnable && !prevVid.outputReadEnable) begin
			next_fieldStart = 1'b1;
			next_armed = 1'b0;
			next_fieldCount = fieldCount + 8'h01;
		end
		if (prevVid.memReadEnable && !sync2.memReadEnable) begin
			next_inBlank = 1'b1;
			next_blankLine = 4'h0;
			next_pixCount = 16'h0000;
			next_updDone = 1'b0;
		end else if (sync2.memReadEnable) begin
			next_inBlank = 1'b0;
		end else if (inBlank) begin
			if (sync2.lineStart && !prevVid.lineStart) begin
				next_blankLine = blankLine + 4'h1;
				next_pixCount = 16'h0000;
			end else if (sync2.pixelValid) begin
				next_pixCount = pixCount + 16'h0001;
			end
			if (!updDone && blankLine == BLANK_LINE_UPD
			    && pixCount == (ACTIVE_PIXELS >> 1)) begin
				next_readbackUpdate = 1'b1;
				next_updDone = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			armed <= 1'b0;
			fieldStart <= 1'b0;
			inBlank <= 1'b0;
			blankLine <= 4'h0;
			pixCount <= 16'h0000;
			updDone <= 1'b0;
			readbackUpdate <= 1'b0;
			fieldCount <= 8'h00;
		end else begin
			armed <= next_armed;
			fieldStart <= next_fieldStart;
			inBlank <= next_inBlank;
			blankLine <= next_blankLine;
			pixCount <= next_pixCount;
			updDone <= next_updDone;
			readbackUpdate <= next_readbackUpdate;
			fieldCount <= next_fieldCount;
		end
	end

	// register bank and bus
	assign accessDone = (avs.read || avs.write) && avsWaitrequest;
	assign isDirect = (avs.address >= ADDR_DIRECT_LO
	                   && avs.address <= ADDR_DIRECT_HI)
	                  || avs.address == ADDR_DIRECT_A
	                  || avs.address == ADDR_DIRECT_B;

	always_comb begin
		next_shadow = shadow;
		next_captured = captured;
		next_activeRegs = activeRegs;
		next_softInitPulse = 1'b0;
		next_candidateSetBit = candidateSetBit;
		next_avsReaddata = avsReaddata;
		next_avsWaitrequest = 1'b1;
		if (fieldStart) begin
			for (int i = 0; i < NUM_REGS; i++)
				next_activeRegs[8*i +: 8] = shadow[i];
		end
		if (readbackUpdate) begin
			for (int i = 0; i < NUM_REGS; i++)
				next_captured[i] = liveResults[8*i +: 8];
		end
		if (accessDone) begin
			next_avsWaitrequest = 1'b0;
			if (avs.write) begin
				if (avs.address == ADDR_SOFT_INIT)
					next_softInitPulse = 1'b1;
				else
					next_shadow[avs.address] = avs.writedata;
				if (avs.address == ADDR_CAND_SET)
					next_candidateSetBit = avs.writedata[CAND_SET_BIT];
			end else if (avs.address == ADDR_STATUS) begin
				next_avsReaddata = fieldCount;
			end else if (isDirect) begin
				next_avsReaddata = liveResults[8*avs.address +: 8];
			end else if (avs.address >= ADDR_READ_BASE) begin
				next_avsReaddata = captured[avs.address];
			end else begin
				next_avsReaddata = shadow[avs.address];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				shadow[i] <= RESET_VALUE;
				captured[i] <= RESET_VALUE;
			end
			activeRegs <= '0;
			softInitPulse <= 1'b0;
			candidateSetBit <= 1'b0;
			avsReaddata <= RESET_VALUE;
			avsWaitrequest <= 1'b1;
		end else begin
			shadow <= next_shadow;
			captured <= next_captured;
			activeRegs <= next_activeRegs;
			softInitPulse <= next_softInitPulse;
			candidateSetBit <= next_candidateSetBit;
			avsReaddata <= next_avsReaddata;
			avsWaitrequest <= next_avsWaitrequest;
		end
	end

	property p_field_start;
		@(posedge clk_sys) disable iff (rst)
		fieldStart |-> $past(sync2.outputReadEnable)
		               && !$past(prevVid.outputReadEnable);
	endproperty
	a_field_start: assert property (p_field_start)
		else $error("field start without read enable rise");

	property p_active_load;
		@(posedge clk_sys) disable iff (rst)
		fieldStart |=> activeRegs[7:0] == $past(shadow[0]);
	endproperty
	a_active_load: assert property (p_active_load)
		else $error("active copy not loaded at field start");

	property p_active_hold;
		@(posedge clk_sys) disable iff (rst)
		!fieldStart |=> $stable(activeRegs);
	endproperty
	a_active_hold: assert property (p_active_hold)
		else $error("active copy changed outside field start");

	property p_capture_hold;
		@(posedge clk_sys) disable iff (rst)
		!readbackUpdate |=> captured[8'h80] == $past(captured[8'h80]);
	endproperty
	a_capture_hold: assert property (p_capture_hold)
		else $error("captured result changed without update");

	property p_upd_point;
		@(posedge clk_sys) disable iff (rst)
		readbackUpdate |-> $past(blankLine) == BLANK_LINE_UPD && updDone;
	endproperty
	a_upd_point: assert property (p_upd_point)
		else $error("readback update at wrong point");

	property p_soft_init;
		@(posedge clk_sys) disable iff (rst)
		accessDone && avs.write && avs.address == ADDR_SOFT_INIT
		|=> softInitPulse ##1 !softInitPulse;
	endproperty
	a_soft_init: assert property (p_soft_init)
		else $error("soft init not immediate");

	property p_cand_set;
		@(posedge clk_sys) disable iff (rst)
		accessDone && avs.write && avs.address == ADDR_CAND_SET
		|=> candidateSetBit == $past(avs.writedata[CAND_SET_BIT]);
	endproperty
	a_cand_set: assert property (p_cand_set)
		else $error("candidate set bit not immediate");

	property p_direct_read;
		@(posedge clk_sys) disable iff (rst)
		accessDone && avs.read && isDirect && avs.address != ADDR_STATUS
		|=> avsReaddata == $past(liveResults[8*avs.address +: 8]);
	endproperty
	a_direct_read: assert property (p_direct_read)
		else $error("direct register read not live");

	property p_field_count;
		@(posedge clk_sys) disable iff (rst)
		fieldStart |-> fieldCount == $past(fieldCount) + 8'h01;
	endproperty
	a_field_count: assert property (p_field_count)
		else $error("field count not advanced");
endmodule : fssr_shadow_regs

// ### fssr_pkg.sv
// package for the field synced shadow register bank
package fssr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_REGS = 256;
	localparam logic [7:0] ADDR_SOFT_INIT = 8'h25;
	localparam logic [7:0] ADDR_CAND_SET = 8'h2F;
	localparam int CAND_SET_BIT = 1;
	localparam logic [7:0] ADDR_DIRECT_LO = 8'hB0;
	localparam logic [7:0] ADDR_DIRECT_HI = 8'hBF;
	localparam logic [7:0] ADDR_DIRECT_A = 8'hAE;
	localparam logic [7:0] ADDR_DIRECT_B = 8'hAF;
	localparam logic [7:0] ADDR_READ_BASE = 8'h80;
	localparam logic [7:0] ADDR_STATUS = 8'hFE;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// readback strobe line within vertical blanking
	localparam logic [3:0] BLANK_LINE_UPD = 4'h4;
	localparam logic [15:0] ACTIVE_PIXELS_DEF = 16'h02D0;

	typedef struct packed {
		logic readStartPulse;
		logic outputReadEnable;
		logic memReadEnable;
		logic pixelValid;
		logic lineStart;
	} fssr_video_t;

	typedef struct packed {
		logic                  read;
		logic                  write;
		logic [ADDR_W-1:0]     address;
		logic [DATA_W-1:0]     writedata;
	} fssr_bus_req_t;
endpackage : fssr_pkg

// ### fssr_host_model.sv
// host side register bus master model
`timescale 1ns/1ps
module fssr_host_model
	import fssr_pkg::*;
(
	// clock
	input  wire logic              clk_sys,
	// slave answer
	input  wire logic [DATA_W-1:0] avsReaddata,
	input  wire logic              avsWaitrequest,
	// request
	output fssr_bus_req_t          avs
);
	initial avs = '0;

	// one access held until waitrequest seen low at an edge
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys);
		avs <= '{read: !w, write: w, address: a, writedata: d};
		do @(posedge clk_sys); while (avsWaitrequest !== 1'b0);
		q = avsReaddata;
		avs <= '0;
	endtask : xfer
endmodule : fssr_host_model

// ### fssr_shadow_regs_tb.sv
// self checking bench for the shadow register bank
`timescale 1ns/1ps
module fssr_shadow_regs_tb
	import fssr_pkg::*;
;
	logic                  clk_sys = 0;
	logic                  rst = 1;
	fssr_bus_req_t         avs;
	logic [DATA_W-1:0]     avsReaddata;
	logic                  avsWaitrequest;
	fssr_video_t           videoPins = '0;
	logic [8*NUM_REGS-1:0] liveResults = '0;
	logic [8*NUM_REGS-1:0] activeRegs;
	logic                  softInitPulse, candidateSetBit;
	logic                  fieldStart, readbackUpdate;
	logic [16:0]           seed = 17'h1180E;
	logic [7:0]            q, a, d, h;
	int miscompares = 0, n_compared = 0, cycles = 0;
	int nFs = 0, nRu = 0, nSi = 0;

	always #4 clk_sys = ~clk_sys;

	fssr_shadow_regs #(.ACTIVE_PIXELS(16'h0008)) DUT (.clk_sys(clk_sys),
		.rst(rst), .avs(avs), .avsReaddata(avsReaddata),
		.avsWaitrequest(avsWaitrequest), .videoPins(videoPins),
		.liveResults(liveResults), .activeRegs(activeRegs),
		.softInitPulse(softInitPulse), .candidateSetBit(candidateSetBit),
		.fieldStart(fieldStart), .readbackUpdate(readbackUpdate));

	fssr_host_model host (.clk_sys(clk_sys), .avsReaddata(avsReaddata),
		.avsWaitrequest(avsWaitrequest), .avs(avs));

	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr

	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// fresh random live results from the core
	task setlive;
		@(posedge clk_sys);
		for (int i = 0; i < NUM_REGS; i++) begin
			seed = lfsr(seed);
			liveResults[8*i+:8] <= seed[7:0];
		end
	endtask : setlive

	// one field: optional read start, active video, six blanking lines
	task field(input logic rs);
		@(posedge clk_sys);
		videoPins.readStartPulse <= rs;
		repeat (3) @(posedge clk_sys);
		videoPins.readStartPulse <= 1'b0;
		videoPins.outputReadEnable <= 1'b1;
		videoPins.memReadEnable <= 1'b1;
		repeat (20) @(posedge clk_sys);
		videoPins.outputReadEnable <= 1'b0;
		videoPins.memReadEnable <= 1'b0;
		repeat (6) begin
			repeat (4) @(posedge clk_sys);
			videoPins.lineStart <= 1'b1;
			@(posedge clk_sys);
			videoPins.lineStart <= 1'b0;
			videoPins.pixelValid <= 1'b1;
			repeat (8) @(posedge clk_sys);
			videoPins.pixelValid <= 1'b0;
		end
		repeat (8) @(posedge clk_sys);
	endtask : field

	always @(posedge clk_sys) begin
		nFs += int'(fieldStart === 1'b1);
		nRu += int'(readbackUpdate === 1'b1);
		nSi += int'(softInitPulse === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		setlive();
		host.xfer(0, 8'h90, 8'h00, q);
		chk("captured before update", q, RESET_VALUE);
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			a = {2'b01, k[1:0], seed[3:0]};
			d = seed[16:9];
			// whole related set written inside one field
			host.xfer(1, a, d, q);
			host.xfer(1, 8'h25, 8'hFF, q);
			host.xfer(1, 8'h2F, {6'h00, k[0], 1'b0}, q);
			repeat (3) @(posedge clk_sys);
			chk("soft init pulses", 8'(nSi), 8'(k + 1));
			chk("candidate set", {7'h00, candidateSetBit}, 8'(k & 1));
			chk("active before field", activeRegs[8*a+:8], RESET_VALUE);
			host.xfer(0, a, 8'h00, q);
			chk("shadow readback", q, d);
			host.xfer(0, 8'hAE + 8'(k), 8'h00, q);
			chk("direct read", q, liveResults[8*(8'hAE + k)+:8]);
			host.xfer(0, 8'hB0 + 8'(k * 5), 8'h00, q);
			chk("direct read", q, liveResults[8*(8'hB0 + k * 5)+:8]);
			field(k != 3);
			chk("field starts", 8'(nFs), 8'(k < 3 ? k + 1 : 3));
			chk("active after field", activeRegs[8*a+:8],
				k < 3 ? d : RESET_VALUE);
			chk("updates per field", 8'(nRu), 8'(k + 1));
			host.xfer(0, 8'h90 + 8'(k), 8'h00, q);
			chk("captured result", q, liveResults[8*(8'h90 + k)+:8]);
			h = liveResults[8*(8'h90 + k)+:8];
			setlive();
			host.xfer(0, 8'h90 + 8'(k), 8'h00, q);
			chk("held between updates", q, h);
			host.xfer(0, ADDR_STATUS, 8'h00, q);
			chk("field counter", q, 8'(k < 3 ? k + 1 : 3));
			if (k == 3)
				chk("no start no load", activeRegs[8*a+:8], RESET_VALUE);
		end
		tally_and_finish();
	end
endmodule : fssr_shadow_regs_tb
